// *** common/usb_cmd_pkg.sv ***
// constants and types for the protocol engine command interpreter
package usb_cmd_pkg;
  // command word layout
  localparam int CODE_LSB = 16;
  localparam int PHASE_LSB = 8;
  localparam logic [7:0] PHASE_COMMAND = 8'h05;
  localparam logic [7:0] PHASE_WRITE = 8'h01;
  localparam logic [7:0] PHASE_READ = 8'h02;
  // device command codes
  localparam logic [7:0] CMD_SET_ADDRESS = 8'hD0;
  localparam logic [7:0] CMD_CONFIGURE = 8'hD8;
  localparam logic [7:0] CMD_SET_MODE = 8'hF3;
  localparam logic [7:0] CMD_FRAME_NUMBER = 8'hF5;
  localparam logic [7:0] CMD_TEST_REG = 8'hFD;
  localparam logic [7:0] CMD_DEVICE_STATUS = 8'hFE;
  localparam logic [7:0] CMD_ERROR_CODE = 8'hFF;
  localparam logic [7:0] CMD_ERROR_STATUS = 8'hFB;
  localparam logic [7:0] CMD_CLEAR_BUFFER = 8'hF2;
  localparam logic [7:0] EP_LAST = 8'h1F;
  localparam logic [7:0] EP_CLR_FIRST = 8'h40;
  localparam logic [7:0] EP_CLR_LAST = 8'h5F;
  // interrupt status bits
  localparam logic [7:0] INT_CMD_EMPTY = 8'h10;
  localparam logic [7:0] INT_DATA_FULL = 8'h20;
  // field positions, widths and fixed values
  localparam int ADDR_EN_BIT = 7;
  localparam int CONF_BIT = 0;
  localparam logic [15:0] TEST_VALUE = 16'hA50F;
  localparam int FRAME_W = 11;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  typedef enum logic [3:0] {
    K_NONE, K_SET_ADDR, K_CONFIG, K_SET_MODE, K_FRAME, K_TEST, K_DEV_STATUS,
    K_ERR_CODE, K_ERR_STATUS, K_SELECT_EP, K_SELECT_CLR, K_CLEAR_BUF
  } cmd_kind_t;
endpackage

// *** design/usb_cmd_engine.sv ***
// command interpreter of the usb protocol engine
`timescale 1ns/1ps
`default_nettype none
module usb_cmd_engine
  import usb_cmd_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  // command code register write
  input  wire logic                   cmd_wr,
  input  wire logic [31:0]            cmd_wdata,
  // command data register read
  input  wire logic                   data_rd,
  // interrupt clear register write
  input  wire logic                   int_clr_wr,
  input  wire logic [7:0]             int_clr_data,
  // usb side events
  input  wire logic                   bus_reset,
  input  wire logic                   status_stage_done,
  input  wire logic                   sof_valid,
  input  wire logic [10:0]            sof_frame,
  input  wire logic [7:0]             ep_status_in,
  input  wire logic [7:0]             clr_buf_result_in,
  input  wire logic [7:0]             dev_status_in,
  input  wire logic [7:0]             err_code_in,
  input  wire logic [7:0]             err_status_in,
  input  wire logic                   pin_function_select,
  // register results
  output logic [7:0]                  device_int_status,
  output logic [7:0]                  command_data_reg,
  // device control outputs
  output logic [6:0]                  function_address,
  output logic                        function_enable,
  output logic                        configured_flag,
  output logic                        good_link,
  output logic                        ctrl_ep_enable,
  output logic                        data_ep_enable,
  output logic [4:0]                  selected_ep,
  output logic                        ep_clear_int,
  output logic                        ep_set_status,
  output logic                        clear_buffer,
  output logic [7:0]                  wr_data,
  output logic                        set_mode_wr,
  output logic                        dev_status_wr
);
  import usb_cmd_pkg::*;

  typedef struct packed {
    logic       cmd_empty;
    logic       data_full;
    logic [7:0] result;
    cmd_kind_t  kind;
    logic [7:0] code;
    logic       byte_idx;
    logic [6:0] addr_pend;
    logic       addr_pend_vld;
    logic       last_was_addr;
    logic [6:0] addr;
    logic       enable;
    logic       configured;
    logic       good_link;
    logic [10:0] frame;
    logic [4:0] sel_ep;
    logic       clr_int;
    logic       set_stat;
    logic       clr_buf;
    logic [7:0] wdata;
    logic       mode_wr;
    logic       stat_wr;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // ----------------------------------------
  // code decode
  // ----------------------------------------
  function automatic cmd_kind_t decode(input logic [7:0] c);
    if (c <= EP_LAST) begin
      decode = K_SELECT_EP;
    end else if (c >= EP_CLR_FIRST && c <= EP_CLR_LAST) begin
      decode = K_SELECT_CLR;
    end else begin
      case (c)
        CMD_SET_ADDRESS:   decode = K_SET_ADDR;
        CMD_CONFIGURE:     decode = K_CONFIG;
        CMD_SET_MODE:      decode = K_SET_MODE;
        CMD_FRAME_NUMBER:  decode = K_FRAME;
        CMD_TEST_REG:      decode = K_TEST;
        CMD_DEVICE_STATUS: decode = K_DEV_STATUS;
        CMD_ERROR_CODE:    decode = K_ERR_CODE;
        CMD_ERROR_STATUS:  decode = K_ERR_STATUS;
        CMD_CLEAR_BUFFER:  decode = K_CLEAR_BUF;
        default:           decode = K_NONE;
      endcase
    end
  endfunction

  logic [7:0] w_code;
  logic [7:0] w_phase;
  logic       w_frame_ok;
  assign w_code  = cmd_wdata[CODE_LSB +: 8];
  assign w_phase = cmd_wdata[PHASE_LSB +: 8];
  assign w_frame_ok = (cmd_wdata[31:24] == 8'h00) && (cmd_wdata[7:0] == 8'h00);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.clr_int  = 1'b0;
    nxt_st.set_stat = 1'b0;
    nxt_st.clr_buf  = 1'b0;
    nxt_st.mode_wr  = 1'b0;
    nxt_st.stat_wr  = 1'b0;
    if (int_clr_wr) begin
      if ((int_clr_data & INT_CMD_EMPTY) != 8'h00) begin
        nxt_st.cmd_empty = 1'b0;
      end
      if ((int_clr_data & INT_DATA_FULL) != 8'h00) begin
        nxt_st.data_full = 1'b0;
      end
    end
    if (sof_valid) begin
      nxt_st.frame = sof_frame;
    end
    if (status_stage_done && st_ff.addr_pend_vld) begin
      nxt_st.addr = st_ff.addr_pend;
      nxt_st.addr_pend_vld = 1'b0;
    end
    if (cmd_wr && w_frame_ok) begin
      // each phase consumed in one cycle; set beats clear
      nxt_st.cmd_empty = 1'b1;
      if (w_phase == PHASE_COMMAND) begin
        nxt_st.code = w_code;
        nxt_st.kind = decode(w_code);
        nxt_st.byte_idx = 1'b0;
        nxt_st.last_was_addr = (decode(w_code) == K_SET_ADDR);
        if (decode(w_code) == K_SELECT_EP || decode(w_code) == K_SELECT_CLR) begin
          nxt_st.sel_ep = w_code[4:0];
        end
        if (decode(w_code) == K_CLEAR_BUF) begin
          nxt_st.clr_buf = 1'b1;
        end
      end else if (w_phase == PHASE_WRITE) begin
        nxt_st.wdata = w_code;
        case (st_ff.kind)
          K_SET_ADDR: begin
            nxt_st.enable = w_code[ADDR_EN_BIT];
            if (st_ff.addr_pend_vld) begin
              nxt_st.addr = w_code[6:0];
              nxt_st.addr_pend_vld = 1'b0;
            end else begin
              nxt_st.addr_pend = w_code[6:0];
              nxt_st.addr_pend_vld = 1'b1;
            end
          end
          K_CONFIG:     nxt_st.configured = w_code[CONF_BIT];
          K_SET_MODE:   nxt_st.mode_wr = 1'b1;
          K_DEV_STATUS: nxt_st.stat_wr = 1'b1;
          K_SELECT_CLR: nxt_st.set_stat = 1'b1;
          default:      nxt_st.wdata = st_ff.wdata;
        endcase
      end else if (w_phase == PHASE_READ && w_code == st_ff.code) begin
        // one result byte per read phase
        nxt_st.byte_idx = ~st_ff.byte_idx;
        nxt_st.data_full = 1'b1;
        case (st_ff.kind)
          K_FRAME:      nxt_st.result = st_ff.byte_idx ?
                                        {5'h00, st_ff.frame[FRAME_W-1:8]} : st_ff.frame[7:0];
          K_TEST:       nxt_st.result = st_ff.byte_idx ? TEST_VALUE[15:8] : TEST_VALUE[7:0];
          K_DEV_STATUS: nxt_st.result = dev_status_in;
          K_ERR_CODE:   nxt_st.result = err_code_in;
          K_ERR_STATUS: nxt_st.result = err_status_in;
          K_SELECT_EP:  nxt_st.result = ep_status_in;
          K_SELECT_CLR: begin
            nxt_st.result = ep_status_in;
            nxt_st.clr_int = 1'b1;
          end
          K_CLEAR_BUF:  nxt_st.result = clr_buf_result_in;
          default:      nxt_st.result = 8'h00;
        endcase
      end
      if (w_phase != PHASE_COMMAND) begin
        nxt_st.last_was_addr = 1'b0;
      end
    end else if (cmd_wr) begin
      nxt_st.cmd_empty = 1'b1;
    end
    if (bus_reset) begin
      nxt_st.addr = ADDR_RESET;
      nxt_st.enable = 1'b1;
      nxt_st.addr_pend_vld = 1'b0;
    end
    nxt_st.good_link = nxt_st.configured && pin_function_select;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff <= '{cmd_empty: 1'b1, kind: K_NONE, addr: ADDR_RESET, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign device_int_status = (st_ff.cmd_empty ? INT_CMD_EMPTY : 8'h00)
                           | (st_ff.data_full ? INT_DATA_FULL : 8'h00);
  assign command_data_reg  = st_ff.result;
  assign function_address  = st_ff.addr;
  assign function_enable   = st_ff.enable;
  assign configured_flag   = st_ff.configured;
  assign good_link         = st_ff.good_link;
  assign ctrl_ep_enable    = 1'b1;
  assign data_ep_enable    = st_ff.configured;
  assign selected_ep       = st_ff.sel_ep;
  assign ep_clear_int      = st_ff.clr_int;
  assign ep_set_status     = st_ff.set_stat;
  assign clear_buffer      = st_ff.clr_buf;
  assign wr_data           = st_ff.wdata;
  assign set_mode_wr       = st_ff.mode_wr;
  assign dev_status_wr     = st_ff.stat_wr;

  logic unused_rd;
  assign unused_rd = data_rd;
endmodule // usb_cmd_engine
`default_nettype wire

// *** testbench/usb_host_model.sv ***
// host side events seen by the command interpreter
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  // clock
  input  wire logic        clk_sys,
  // bus events
  output logic             bus_reset,
  output logic             status_stage_done,
  output logic             sof_valid,
  output logic [10:0]      sof_frame
);
  initial begin
    bus_reset = 1'b0;
    status_stage_done = 1'b0;
    sof_valid = 1'b0;
    sof_frame = 11'h7FF;
  end
  task sof(input logic [10:0] f);
    sof_valid <= 1'b1;
    sof_frame <= f;
    @(posedge clk_sys);
    sof_valid <= 1'b0;
    sof_frame <= ~f;
    @(posedge clk_sys);
  endtask
  task stage();
    status_stage_done <= 1'b1;
    @(posedge clk_sys);
    status_stage_done <= 1'b0;
    @(posedge clk_sys);
  endtask
  task usb_reset();
    bus_reset <= 1'b1;
    @(posedge clk_sys);
    bus_reset <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule // usb_host_model
`default_nettype wire

// *** testbench/usb_cmd_engine_checker.sv ***
// assertions on the command interpreter ports
`timescale 1ns/1ps
`default_nettype none
module usb_cmd_checker
  import usb_cmd_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        cmd_wr,
  input wire logic [31:0] cmd_wdata,
  input wire logic        int_clr_wr,
  input wire logic [7:0]  int_clr_data,
  input wire logic        bus_reset,
  input wire logic        status_stage_done,
  input wire logic        pin_function_select,
  input wire logic [7:0]  device_int_status,
  input wire logic [6:0]  function_address,
  input wire logic        function_enable,
  input wire logic        configured_flag,
  input wire logic        good_link,
  input wire logic        ctrl_ep_enable,
  input wire logic        data_ep_enable
);
  logic [7:0] cur_ff;
  wire wr_ph = cmd_wr && cmd_wdata[15:8] == PHASE_WRITE;
  wire rd_ph = cmd_wr && cmd_wdata[15:8] == PHASE_READ && cmd_wdata[23:16] == cur_ff;
  wire addr_ev = status_stage_done || bus_reset || cmd_wr;
  always_ff @(posedge clk_sys) begin
    if (cmd_wr && cmd_wdata[15:8] == PHASE_COMMAND) begin
      cur_ff <= cmd_wdata[23:16];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_conf_wr;
    wr_ph && cur_ff == CMD_CONFIGURE;
  endsequence
  sequence s_link;
    (configured_flag && pin_function_select) [*2];
  endsequence
  AST_EMPTY_SET: assert property (cmd_wr |=> device_int_status[4])
    else $error("cmd empty not set");
  AST_FULL_SET: assert property (rd_ph |=> device_int_status[5])
    else $error("data full not set");
  AST_FULL_CLR: assert property (int_clr_wr && int_clr_data[5] && !rd_ph
    |=> !device_int_status[5]) else $error("data full not cleared");
  AST_CONF: assert property (s_conf_wr |=> configured_flag == $past(cmd_wdata[16]))
    else $error("configured flag wrong");
  AST_DATA_EP: assert property (data_ep_enable == configured_flag)
    else $error("data endpoints wrong");
  AST_CTRL_EP: assert property (ctrl_ep_enable)
    else $error("control endpoint off");
  AST_LINK: assert property (s_link |-> good_link)
    else $error("good link missing");
  AST_BUS_RST: assert property (bus_reset |=> !function_address && function_enable)
    else $error("bus reset wrong");
  AST_EN_NOW: assert property (wr_ph && cur_ff == CMD_SET_ADDRESS && !bus_reset
    |=> function_enable == $past(cmd_wdata[23])) else $error("enable not applied");
  AST_ADDR_HOLD: assert property (!$stable(function_address) |-> $past(addr_ev))
    else $error("address moved alone");
endmodule // usb_cmd_checker
bind usb_cmd_engine usb_cmd_checker CHK (.clk_sys(clk_sys), .reset(reset),
  .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .int_clr_wr(int_clr_wr),
  .int_clr_data(int_clr_data), .bus_reset(bus_reset),
  .status_stage_done(status_stage_done), .pin_function_select(pin_function_select),
  .device_int_status(device_int_status), .function_address(function_address),
  .function_enable(function_enable), .configured_flag(configured_flag),
  .good_link(good_link), .ctrl_ep_enable(ctrl_ep_enable),
  .data_ep_enable(data_ep_enable));
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import usb_cmd_pkg::*;
  logic clk_sys, reset, cmd_wr, data_rd, int_clr_wr, pin_function_select;
  logic [31:0] cmd_wdata;
  logic [7:0] int_clr_data, device_int_status, command_data_reg;
  logic [6:0] function_address;
  logic [4:0] selected_ep;
  logic function_enable, configured_flag, good_link, ctrl_ep_enable, data_ep_enable;
  logic bus_reset, status_stage_done, sof_valid;
  logic [10:0] sof_frame;
  logic [7:0] dev_status;
  int error_cnt = 0;
  int checked = 0;
  usb_host_model HOST (.clk_sys(clk_sys), .bus_reset(bus_reset),
    .status_stage_done(status_stage_done), .sof_valid(sof_valid), .sof_frame(sof_frame));
  usb_cmd_engine DUT (.clk_sys(clk_sys), .reset(reset), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata), .data_rd(data_rd), .int_clr_wr(int_clr_wr),
    .int_clr_data(int_clr_data), .bus_reset(bus_reset),
    .status_stage_done(status_stage_done), .sof_valid(sof_valid), .sof_frame(sof_frame),
    .ep_status_in(8'h55), .clr_buf_result_in(8'h44), .dev_status_in(dev_status),
    .err_code_in(8'h22), .err_status_in(8'h33), .pin_function_select(pin_function_select),
    .device_int_status(device_int_status), .command_data_reg(command_data_reg),
    .function_address(function_address), .function_enable(function_enable),
    .configured_flag(configured_flag), .good_link(good_link),
    .ctrl_ep_enable(ctrl_ep_enable), .data_ep_enable(data_ep_enable),
    .selected_ep(selected_ep), .ep_clear_int(), .ep_set_status(), .clear_buffer(),
    .wr_data(), .set_mode_wr(), .dev_status_wr());
  always #5 clk_sys = ~clk_sys;
  task chk(input logic [7:0] a, input logic [7:0] e);
    checked++;
    if (a !== e) begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task wr(input logic [31:0] w);
    cmd_wr <= 1'b1;
    cmd_wdata <= w;
    @(posedge clk_sys);
    cmd_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task cmd(input logic [7:0] c);
    wr({8'h00, c, PHASE_COMMAND, 8'h00});
  endtask
  task wdat(input logic [7:0] b);
    wr({8'h00, b, PHASE_WRITE, 8'h00});
  endtask
  task clr(input logic [7:0] d);
    int_clr_wr <= 1'b1;
    int_clr_data <= d;
    @(posedge clk_sys);
    int_clr_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [7:0] c, input logic [7:0] e);
    wr({8'h00, c, PHASE_READ, 8'h00});
    data_rd <= 1'b1;
    chk(device_int_status, 8'h30);
    chk(command_data_reg, e);
    @(posedge clk_sys);
    data_rd <= 1'b0;
    clr(8'h30);
    chk(device_int_status, 8'h00);
  endtask
  task t_reset();
    chk(device_int_status, 8'h10);
    chk({function_enable, function_address}, 8'h00);
    $display("t_reset done");
  endtask
  task t_frame();
    HOST.sof(11'h5A3);
    cmd(CMD_FRAME_NUMBER);
    rd(CMD_FRAME_NUMBER, 8'hA3);
    rd(CMD_FRAME_NUMBER, 8'h05);
    cmd(CMD_TEST_REG);
    rd(CMD_TEST_REG, 8'h0F);
    rd(CMD_TEST_REG, 8'hA5);
    $display("t_frame done");
  endtask
  task t_addr();
    cmd(CMD_SET_ADDRESS);
    wdat(8'h85);
    chk({function_enable, function_address}, 8'h80);
    HOST.stage();
    chk({function_enable, function_address}, 8'h85);
    cmd(CMD_SET_ADDRESS);
    wdat(8'h13);
    cmd(CMD_SET_ADDRESS);
    wdat(8'h13);
    chk({function_enable, function_address}, 8'h13);
    $display("t_addr done");
  endtask
  task t_conf();
    cmd(CMD_CONFIGURE);
    wdat(8'h01);
    @(posedge clk_sys);
    chk({configured_flag, data_ep_enable, ctrl_ep_enable, good_link}, 8'h0F);
    pin_function_select <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({configured_flag, data_ep_enable, ctrl_ep_enable, good_link}, 8'h0E);
    pin_function_select <= 1'b1;
    cmd(CMD_CONFIGURE);
    wdat(8'h00);
    @(posedge clk_sys);
    chk({configured_flag, data_ep_enable, ctrl_ep_enable, good_link}, 8'h02);
    HOST.usb_reset();
    chk({function_enable, function_address}, 8'h80);
    $display("t_conf done");
  endtask
  task t_ep();
    logic [15:0] tab [5];
    tab = '{16'hFE11, 16'hFF22, 16'hFB33, 16'hF244, 16'h4355};
    cmd(8'h03);
    chk({3'h0, selected_ep}, 8'h03);
    rd(8'h03, 8'h55);
    for (int i = 0; i < 5; i++) begin
      cmd(tab[i][15:8]);
      rd(tab[i][15:8], tab[i][7:0]);
    end
    chk({3'h0, selected_ep}, 8'h03);
    $display("t_ep done");
  endtask
  task stop_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    {cmd_wr, data_rd, int_clr_wr, cmd_wdata, int_clr_data} = '0;
    pin_function_select = 1'b1;
    dev_status = 8'h11;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_frame();
    t_addr();
    t_conf();
    t_ep();
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end
endmodule // testbench
`default_nettype wire
